// *** lbwcs_regs.svh ***
// Contract
// RL1 - Warm-up counter width covers configured maximum
// RL2 - Default warm-up maximum 255, eight bits
// RL3 - Programmer preloads generator at begin minus warm-ups
// RL4 - Run warm-ups then range; signature only range
// RL5 - Begin at zero clears signature register
// RL6 - Fewer warm-ups start at shifted generator state
// RL7 - Default first pattern index is zero
// RL8 - Built-in default run uses hard-wired values
// RL9 - Warm-up register optional with configurable default
// RL10 - Optional chain-test count register with default
// RL11 - Chain tests after warm-ups, before others
// RL12 - Chain tests take lowest pattern indices
// RL13 - Chain-test capture: no clocks, one cycle
// RL14 - Capture trigger low throughout chain tests
// RL15 - Warm-up unloads never reach signature register
// RL16 - Warm-up end copies pattern counter over
// RL17 - One machine orders phases, skips empty ones
// RL18 - Generator advances one pattern per warm-up
`ifndef LBWCS_REGS_SVH
`define LBWCS_REGS_SVH
`define LBWCS_WARMUP_MAX      255
`define LBWCS_WARMUP_DEFAULT  128
`define LBWCS_CHAIN_MAX       16
`define LBWCS_CHAIN_DEFAULT   7
`define LBWCS_SR_DEFAULT      0
`define LBWCS_BEGIN_RESET     0
`define LBWCS_END_DEFAULT     1023
`define LBWCS_PAT_W           16
`define LBWCS_SHIFT_LEN       32
`define LBWCS_SCAN_CAPT       4
`define LBWCS_CHAIN_CAPT      1
`define LBWCS_SR_CAPT         2
`define LBWCS_PRPG_W          31
`define LBWCS_PRPG_SEED       31'h0000_0001
`define LBWCS_PRPG_TAPS       31'h4800_0000
`endif

// *** lbwcs_pkg.sv ***
package lbwcs_pkg;
    typedef enum logic [2:0] {
        LBWCS_IDLE  = 3'h0,
        LBWCS_SHIFT = 3'h1,
        LBWCS_CAPT  = 3'h3,
        LBWCS_UNLD  = 3'h2,
        LBWCS_DONE  = 3'h6
    } lbwcs_state_t;

    typedef enum logic [1:0] {
        LBWCS_PH_WARM  = 2'h0,
        LBWCS_PH_CHAIN = 2'h1,
        LBWCS_PH_SR    = 2'h3,
        LBWCS_PH_SCAN  = 2'h2
    } lbwcs_phase_t;

    typedef struct packed {
        logic shiftPhase;
        logic captureEn;
        logic asyncSetResetEn;
        logic misrAccum;
        logic misrClear;
        logic prpgAdvance;
        logic busy;
        logic done;
    } lbwcs_ctrl_t;

    typedef struct packed {
        logic select;
        logic capture;
        logic shift;
        logic update;
        logic serialIn;
    } lbwcs_prog_t;
endpackage

// *** lbwcs_prpg.sv ***
`timescale 1ns/1ps
`include "lbwcs_regs.svh"
module lbwcs_prpg #(
    parameter int unsigned        W    = `LBWCS_PRPG_W,
    parameter logic [W-1:0]       TAPS = `LBWCS_PRPG_TAPS
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic         load,
    input  wire logic [W-1:0] seed,
    input  wire logic         advance,
    output logic      [W-1:0] state,
    output logic              scanBit
);
    logic [W-1:0] state_d;
    logic         bit_d;

    initial begin
        if (W < 2) begin
            $error("lbwcs_prpg: width below 2");
        end
    end

    always_comb begin
        state_d = state;
        bit_d   = scanBit;
        if (load) begin
            state_d = seed;
        end
        // Load and step may share an edge: the first pattern keeps every step
        if (advance) begin
            bit_d   = state_d[0];
            state_d = {^(state_d & TAPS), state_d[W-1:1]};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state   <= W'(`LBWCS_PRPG_SEED);
            scanBit <= 1'b0;
        end else begin
            state   <= state_d;
            scanBit <= bit_d;
        end
    end
endmodule

// *** lbwcs_sequencer.sv ***
`timescale 1ns/1ps
`include "lbwcs_regs.svh"
module lbwcs_sequencer #(
    parameter int unsigned WARMUP_PRESENT = 1,
    parameter int unsigned WARMUP_MAX     = `LBWCS_WARMUP_MAX,
    parameter int unsigned WARMUP_DEFAULT = `LBWCS_WARMUP_DEFAULT,
    parameter int unsigned CHAIN_PRESENT  = 1,
    parameter int unsigned CHAIN_MAX      = `LBWCS_CHAIN_MAX,
    parameter int unsigned CHAIN_DEFAULT  = `LBWCS_CHAIN_DEFAULT,
    parameter int unsigned SHIFT_LEN      = `LBWCS_SHIFT_LEN,
    parameter int unsigned SCAN_CAPT      = `LBWCS_SCAN_CAPT
) (
    input  wire logic               sys_clk,
    input  wire logic               srst,
    input  wire logic               start,
    input  wire logic               builtinDefaultRun,
    input  wire lbwcs_pkg::lbwcs_prog_t prog,
    output logic                    progSo,
    output lbwcs_pkg::lbwcs_ctrl_t  scanCtrl,
    output lbwcs_pkg::lbwcs_phase_t activePhase,
    output logic [`LBWCS_PAT_W-1:0] patternIndex,
    output logic                    prpgScanBit
);
    import lbwcs_pkg::*;

    // Register widths follow the configured maxima
    localparam int unsigned WW = (WARMUP_PRESENT != 0) ? $clog2(WARMUP_MAX + 1) : 1;
    localparam int unsigned CW = $clog2(CHAIN_MAX + 1);
    localparam int unsigned PW = `LBWCS_PAT_W;
    localparam int unsigned GW = `LBWCS_PRPG_W;
    localparam int unsigned SW = $clog2(SHIFT_LEN + 1);
    localparam int unsigned LW = WW + 2 * PW + 2 * CW + GW;

    // RL1 RL2 sizing checks
    initial begin
        if (WARMUP_MAX < 1 || WARMUP_DEFAULT > WARMUP_MAX) begin
            $error("lbwcs_sequencer: bad warm-up maximum or default");
        end
        if (CHAIN_MAX < 1 || CHAIN_DEFAULT > CHAIN_MAX) begin
            $error("lbwcs_sequencer: bad chain-test maximum or default");
        end
        if (SHIFT_LEN < 2 || SCAN_CAPT < 1 || SCAN_CAPT > 15) begin
            $error("lbwcs_sequencer: bad shift or capture length");
        end
    end

    // Programmed configuration and the serial shadow that reaches it
    logic [WW-1:0] warm_q, warm_d;
    logic [PW-1:0] begin_q, begin_d, end_q, end_d;
    logic [CW-1:0] chain_q, chain_d, sr_q, sr_d;
    logic [GW-1:0] seed_q, seed_d;
    logic [LW-1:0] shadow_q, shadow_d;
    logic          so_q, so_d;

    // Sequencer state
    lbwcs_state_t  st_q, st_d;
    lbwcs_phase_t  ph_q, ph_d;
    logic [WW-1:0] warmRem_q, warmRem_d;
    logic [PW-1:0] pat_q, pat_d, runEnd_q, runEnd_d;
    logic [CW-1:0] runChain_q, runChain_d, runSr_q, runSr_d;
    logic [SW-1:0] sh_q, sh_d;
    logic [3:0]    cap_q, cap_d;
    logic          obs_q, obs_d;
    lbwcs_ctrl_t   ctrl_q, ctrl_d;
    logic          warmCopy;
    logic          startTake;
    logic          prpgLoad;
    logic [GW-1:0] prpgSeed;
    logic [WW-1:0] startWarm;
    logic [PW-1:0] startBegin;

    function automatic lbwcs_phase_t phaseOf(input logic [PW-1:0] idx,
                                             input logic [CW-1:0] nChain,
                                             input logic [CW-1:0] nSr);
        logic [PW:0] lim;
        lim = {1'b0, PW'(nChain)} + {1'b0, PW'(nSr)};
        // RL12 chain tests first
        if ({1'b0, idx} < {1'b0, PW'(nChain)}) begin
            return LBWCS_PH_CHAIN;
        end else if ({1'b0, idx} < lim) begin
            return LBWCS_PH_SR;
        end
        return LBWCS_PH_SCAN;
    endfunction

    function automatic logic [3:0] captLen(input lbwcs_phase_t ph);
        unique case (ph)
            LBWCS_PH_CHAIN: return 4'(`LBWCS_CHAIN_CAPT);
            LBWCS_PH_SR:    return 4'(`LBWCS_SR_CAPT);
            LBWCS_PH_SCAN:  return 4'(SCAN_CAPT);
            LBWCS_PH_WARM:  return 4'(SCAN_CAPT);
        endcase
    endfunction

    assign startTake  = start && (st_q == LBWCS_IDLE);
    // RL8 hard-wired values in built-in default run
    assign startWarm  = (builtinDefaultRun && WARMUP_PRESENT != 0) ? WW'(WARMUP_DEFAULT)
                      : warm_q;
    assign startBegin = builtinDefaultRun ? PW'(`LBWCS_BEGIN_RESET) : begin_q;
    assign prpgSeed   = builtinDefaultRun ? GW'(`LBWCS_PRPG_SEED) : seed_q;
    assign prpgLoad   = startTake;

    // Configuration chain: capture reads state, update writes when not busy (idle or done)
    always_comb begin
        warm_d   = warm_q;
        begin_d  = begin_q;
        end_d    = end_q;
        chain_d  = chain_q;
        sr_d     = sr_q;
        seed_d   = seed_q;
        shadow_d = shadow_q;
        so_d     = so_q;
        if (prog.select && prog.capture) begin
            shadow_d = {warm_q, begin_q, end_q, chain_q, sr_q, seed_q};
        end else if (prog.select && prog.shift) begin
            so_d     = shadow_q[0];
            shadow_d = {prog.serialIn, shadow_q[LW-1:1]};
        end else if (prog.select && prog.update && !ctrl_q.busy) begin
            {warm_d, begin_d, end_d, chain_d, sr_d, seed_d} = shadow_q;
        end
        // RL9 no warm-up phase when built without it
        if (WARMUP_PRESENT == 0) begin
            warm_d = '0;
        end else if (warmCopy) begin
            // RL16 pattern counter copied at warm-up end
            warm_d = WW'(pat_q);
        end
        // RL10 chain-test register only when built
        if (CHAIN_PRESENT == 0) begin
            chain_d = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            warm_q   <= (WARMUP_PRESENT != 0) ? WW'(WARMUP_DEFAULT) : '0;
            // RL7 first pattern index defaults to zero
            begin_q  <= PW'(`LBWCS_BEGIN_RESET);
            end_q    <= PW'(`LBWCS_END_DEFAULT);
            chain_q  <= (CHAIN_PRESENT != 0) ? CW'(CHAIN_DEFAULT) : '0;
            sr_q     <= CW'(`LBWCS_SR_DEFAULT);
            seed_q   <= GW'(`LBWCS_PRPG_SEED);
            shadow_q <= '0;
            so_q     <= 1'b0;
        end else begin
            warm_q   <= warm_d;
            begin_q  <= begin_d;
            end_q    <= end_d;
            chain_q  <= chain_d;
            sr_q     <= sr_d;
            seed_q   <= seed_d;
            shadow_q <= shadow_d;
            so_q     <= so_d;
        end
    end

    // RL17 phase sequencer
    always_comb begin
        st_d       = st_q;
        ph_d       = ph_q;
        warmRem_d  = warmRem_q;
        pat_d      = pat_q;
        runEnd_d   = runEnd_q;
        runChain_d = runChain_q;
        runSr_d    = runSr_q;
        sh_d       = sh_q;
        cap_d      = cap_q;
        obs_d      = obs_q;
        warmCopy   = 1'b0;
        ctrl_d     = '0;
        unique case (st_q)
            LBWCS_IDLE: begin
                if (startTake) begin
                    runChain_d = (builtinDefaultRun && CHAIN_PRESENT != 0)
                               ? CW'(CHAIN_DEFAULT) : chain_q;
                    runSr_d    = builtinDefaultRun ? CW'(`LBWCS_SR_DEFAULT) : sr_q;
                    runEnd_d   = builtinDefaultRun ? PW'(`LBWCS_END_DEFAULT) : end_q;
                    warmRem_d  = startWarm;
                    pat_d      = startBegin;
                    sh_d       = '0;
                    obs_d      = 1'b0;
                    st_d       = LBWCS_SHIFT;
                    // RL11 empty warm-up skipped at once
                    ph_d       = (startWarm != '0) ? LBWCS_PH_WARM
                               : phaseOf(startBegin, runChain_d, runSr_d);
                    // RL5 signature cleared only when the run begins at zero
                    ctrl_d.misrClear = (startBegin == '0);
                end
            end
            LBWCS_SHIFT: begin
                sh_d = sh_q + SW'(1);
                if (sh_q == SW'(SHIFT_LEN - 1)) begin
                    sh_d  = '0;
                    cap_d = '0;
                    st_d  = LBWCS_CAPT;
                end
            end
            LBWCS_CAPT: begin
                cap_d = cap_q + 4'h1;
                // RL13 capture window length per phase
                if (cap_q == captLen(ph_q) - 4'h1) begin
                    // RL4 RL15 warm-up unloads marked unobserved
                    obs_d = (ph_q != LBWCS_PH_WARM);
                    st_d  = LBWCS_SHIFT;
                    if (ph_q == LBWCS_PH_WARM) begin
                        warmRem_d = warmRem_q - WW'(1);
                        if (warmRem_q == WW'(1)) begin
                            warmCopy = 1'b1;
                            ph_d     = phaseOf(pat_q, runChain_q, runSr_q);
                        end
                    end else if (pat_q >= runEnd_q) begin
                        st_d = LBWCS_UNLD;
                    end else begin
                        pat_d = pat_q + PW'(1);
                        ph_d  = phaseOf(pat_d, runChain_q, runSr_q);
                    end
                end
            end
            LBWCS_UNLD: begin
                sh_d = sh_q + SW'(1);
                if (sh_q == SW'(SHIFT_LEN - 1)) begin
                    st_d = LBWCS_DONE;
                end
            end
            LBWCS_DONE: begin
                if (!start) begin
                    st_d = LBWCS_IDLE;
                end
            end
            default: begin
                st_d = LBWCS_IDLE;
            end
        endcase
        // Outputs registered from next state so they leave flops aligned
        ctrl_d.shiftPhase      = (st_d == LBWCS_SHIFT) || (st_d == LBWCS_UNLD);
        // RL18 generator steps every load shift cycle, warm-up included, but not in the final unload
        ctrl_d.prpgAdvance     = (st_d == LBWCS_SHIFT);
        // RL14 no capture trigger outside scan phase
        ctrl_d.captureEn       = (st_d == LBWCS_CAPT) && (ph_d == LBWCS_PH_SCAN);
        ctrl_d.asyncSetResetEn = (st_d == LBWCS_CAPT) && (ph_d == LBWCS_PH_SR);
        // RL4 RL15 only the requested range is folded in
        ctrl_d.misrAccum       = ((st_d == LBWCS_SHIFT) && obs_d) || (st_d == LBWCS_UNLD);
        ctrl_d.busy            = (st_d != LBWCS_IDLE) && (st_d != LBWCS_DONE);
        ctrl_d.done            = (st_d == LBWCS_DONE);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q       <= LBWCS_IDLE;
            ph_q       <= LBWCS_PH_WARM;
            warmRem_q  <= '0;
            pat_q      <= '0;
            runEnd_q   <= '0;
            runChain_q <= '0;
            runSr_q    <= '0;
            sh_q       <= '0;
            cap_q      <= '0;
            obs_q      <= 1'b0;
            ctrl_q     <= '0;
        end else begin
            st_q       <= st_d;
            ph_q       <= ph_d;
            warmRem_q  <= warmRem_d;
            pat_q      <= pat_d;
            runEnd_q   <= runEnd_d;
            runChain_q <= runChain_d;
            runSr_q    <= runSr_d;
            sh_q       <= sh_d;
            cap_q      <= cap_d;
            obs_q      <= obs_d;
            ctrl_q     <= ctrl_d;
        end
    end

    // RL3 RL6 generator reloaded at start from programmed seed, or hard-wired seed in built-in default run
    lbwcs_prpg #(
        .W    (GW),
        .TAPS (GW'(`LBWCS_PRPG_TAPS))
    ) u_prpg (
        .sys_clk (sys_clk),
        .srst    (srst),
        .load    (prpgLoad),
        .seed    (prpgSeed),
        .advance (ctrl_d.prpgAdvance),
        .state   (),
        .scanBit (prpgScanBit)
    );

    assign progSo       = so_q;
    assign scanCtrl     = ctrl_q;
    assign activePhase  = ph_q;
    assign patternIndex = pat_q;

    // Helper: shift cycles seen since the last capture
    logic [SW:0] advCnt_q;
    always_ff @(posedge sys_clk) begin
        if (srst || st_q == LBWCS_CAPT || st_q == LBWCS_IDLE) begin
            advCnt_q <= '0;
        end else if (ctrl_q.prpgAdvance) begin
            advCnt_q <= advCnt_q + (SW + 1)'(1);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence chainCaptEntry;
        (st_q == LBWCS_SHIFT) ##1 (st_q == LBWCS_CAPT && ph_q == LBWCS_PH_CHAIN);
    endsequence

    sequence startAtZero;
        startTake && (startBegin == '0);
    endsequence

    a_chain_no_trigger: assert property ( // RL14
        (ph_q == LBWCS_PH_CHAIN) |-> !ctrl_q.captureEn)
        else $error("capture trigger raised during chain test");

    a_chain_capt_width: assert property ( // RL13
        chainCaptEntry |=> (st_q != LBWCS_CAPT) && !ctrl_q.captureEn)
        else $error("chain-test capture window not one cycle");

    a_warm_unload_masked: assert property ( // RL15
        (st_q == LBWCS_SHIFT && !obs_q) |-> !ctrl_q.misrAccum)
        else $error("warm-up unload folded into signature");

    a_range_observed: assert property ( // RL4
        (st_q == LBWCS_CAPT && ph_q != LBWCS_PH_WARM && cap_q == captLen(ph_q) - 4'h1
         && pat_q < runEnd_q) |=> ctrl_q.misrAccum [*2])
        else $error("requested pattern unload not accumulated");

    a_zero_begin_clear: assert property ( // RL5
        startAtZero |=> ctrl_q.misrClear ##1 !ctrl_q.misrClear)
        else $error("signature not cleared for run from zero");

    a_default_begin: assert property ( // RL7
        $past(srst) |-> (begin_q == '0))
        else $error("first pattern index not zero after reset");

    a_builtin_warm: assert property ( // RL8
        (startTake && builtinDefaultRun)
        |=> (warmRem_q == ((WARMUP_PRESENT != 0) ? WW'(WARMUP_DEFAULT) : '0)))
        else $error("built-in run did not use hard-wired warm-up count");

    a_warm_copy: assert property ( // RL16
        warmCopy |=> (warm_q == WW'($past(pat_q))))
        else $error("warm-up register not loaded from pattern counter");

    a_phase_order: assert property ( // RL11
        (ph_q != LBWCS_PH_WARM && st_q != LBWCS_IDLE && st_q != LBWCS_DONE)
        |=> (ph_q != LBWCS_PH_WARM))
        else $error("warm-up phase re-entered after later phase");

    a_chain_lowest: assert property ( // RL12
        (st_q == LBWCS_SHIFT && ph_q != LBWCS_PH_WARM && pat_q < PW'(runChain_q))
        |-> (ph_q == LBWCS_PH_CHAIN))
        else $error("low pattern index not a chain test");

    a_prpg_per_pattern: assert property ( // RL18
        (st_q == LBWCS_CAPT && $past(st_q) == LBWCS_SHIFT)
        |-> (advCnt_q == (SW + 1)'(SHIFT_LEN)))
        else $error("generator did not advance one pattern length");
endmodule

// *** lbwcs_scan_model.sv ***
`timescale 1ns/1ps
module lbwcs_scan_model
    import lbwcs_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    clrStats,
    input  wire lbwcs_pkg::lbwcs_ctrl_t  scanCtrl,
    input  wire lbwcs_pkg::lbwcs_phase_t activePhase,
    output logic [31:0]                  patCnt [4],
    output logic [31:0]                  captCnt [4],
    output logic [31:0]                  trigCnt [4],
    output logic [31:0]                  asrCnt,
    output logic [31:0]                  accumCnt,
    output logic [31:0]                  advCnt,
    output logic [31:0]                  clearCnt,
    output logic [31:0]                  orderBad
);
    logic         prevShift;
    lbwcs_phase_t lastPhase;

    function automatic int rank(input lbwcs_phase_t p);
        return (p == LBWCS_PH_WARM) ? 0 : (p == LBWCS_PH_CHAIN) ? 1 : (p == LBWCS_PH_SR) ? 2 : 3;
    endfunction

    // Stats reset by the bench only, so a design reset mid-run cannot hide counts
    always_ff @(posedge sys_clk) begin
        if (clrStats) begin
            for (int i = 0; i < 4; i++) begin
                patCnt[i]  <= '0;
                captCnt[i] <= '0;
                trigCnt[i] <= '0;
            end
            asrCnt    <= '0;
            accumCnt  <= '0;
            advCnt    <= '0;
            clearCnt  <= '0;
            orderBad  <= '0;
            prevShift <= 1'b0;
            lastPhase <= LBWCS_PH_WARM;
        end else begin
            clearCnt <= clearCnt + 32'(scanCtrl.misrClear);
            if (scanCtrl.busy) begin
                prevShift <= scanCtrl.shiftPhase;
                lastPhase <= activePhase;
                if (rank(activePhase) < rank(lastPhase)) begin
                    orderBad <= orderBad + 32'h1;
                end
                if (!scanCtrl.shiftPhase) begin
                    captCnt[activePhase] <= captCnt[activePhase] + 32'h1;
                    if (prevShift) begin
                        patCnt[activePhase] <= patCnt[activePhase] + 32'h1;
                    end
                end
                // Clock controller pulses capture clocks only on the trigger
                if (scanCtrl.captureEn) begin
                    trigCnt[activePhase] <= trigCnt[activePhase] + 32'h1;
                end
                asrCnt   <= asrCnt + 32'(scanCtrl.asyncSetResetEn);
                accumCnt <= accumCnt + 32'(scanCtrl.misrAccum);
                advCnt   <= advCnt + 32'(scanCtrl.prpgAdvance);
            end
        end
    end
endmodule

// *** lbist_warmup_chain_test_sequencer_tb.sv ***
`timescale 1ns/1ps
`include "lbwcs_regs.svh"
module lbist_warmup_chain_test_sequencer_tb;
    import lbwcs_pkg::*;
    localparam int L     = 4;
    localparam int LIMIT = 60000;
    typedef struct {int w; int b; int e; int c; int s;} lbwcs_row_t;

    logic                    sys_clk           = 1'b0;
    logic                    srst              = 1'b1;
    logic                    start             = 1'b0;
    logic                    builtinDefaultRun = 1'b0;
    logic                    clrStats          = 1'b0;
    lbwcs_prog_t             prog              = '0;
    logic                    progSo;
    lbwcs_ctrl_t             scanCtrl;
    lbwcs_phase_t            activePhase;
    logic [`LBWCS_PAT_W-1:0] patternIndex;
    logic                    prpgScanBit;
    logic [31:0]             patCnt [4];
    logic [31:0]             captCnt [4];
    logic [31:0]             trigCnt [4];
    logic [31:0]             asrCnt, accumCnt, advCnt, clearCnt, orderBad;
    int                      fails     = 0;
    int                      numChecks = 0;
    int                      cycles    = 0;
    lbwcs_row_t              rows [6]  = '{'{1, 0, 0, 1, 0}, '{0, 0, 9, 3, 2}, '{2, 5, 8, 7, 0},
                                           '{3, 0, 2, 0, 0}, '{2, 2, 4, 0, 4}, '{255, 0, 1, 0, 1}};

    always #20 sys_clk = ~sys_clk;

    lbwcs_sequencer #(.SHIFT_LEN(L)) uut (
        .sys_clk          (sys_clk),
        .srst             (srst),
        .start            (start),
        .builtinDefaultRun(builtinDefaultRun),
        .prog             (prog),
        .progSo           (progSo),
        .scanCtrl         (scanCtrl),
        .activePhase      (activePhase),
        .patternIndex     (patternIndex),
        .prpgScanBit      (prpgScanBit)
    );

    lbwcs_scan_model chains (
        .sys_clk    (sys_clk),
        .clrStats   (clrStats),
        .scanCtrl   (scanCtrl),
        .activePhase(activePhase),
        .patCnt     (patCnt),
        .captCnt    (captCnt),
        .trigCnt    (trigCnt),
        .asrCnt     (asrCnt),
        .accumCnt   (accumCnt),
        .advCnt     (advCnt),
        .clearCnt   (clearCnt),
        .orderBad   (orderBad)
    );

    function automatic logic [80:0] pack(input lbwcs_row_t r, input logic [30:0] seed);
        return {r.w[7:0], r.b[15:0], r.e[15:0], r.c[4:0], r.s[4:0], seed};
    endfunction

    task automatic chk(input string name, input logic [80:0] exp, input logic [80:0] got);
        numChecks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
            fails++;
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Capture, shift all 81 shadow bits out LSB first, optionally update
    task automatic xfer(input logic [80:0] din, input logic doUpd, output logic [80:0] dout);
        @(posedge sys_clk) prog <= 5'b11000;
        @(posedge sys_clk) prog <= {4'b1010, din[0]};
        for (int i = 0; i < 81; i++) begin
            @(posedge sys_clk);
            if (i > 0) dout[i-1] = progSo;
            prog <= (i < 80) ? {4'b1010, din[(i+1)%81]} : {3'b100, doUpd, 1'b0};
        end
        @(posedge sys_clk) dout[80] = progSo;
        prog <= '0;
    endtask

    task automatic program_cfg(input lbwcs_row_t r, input logic [30:0] seed);
        logic [80:0] back;
        xfer(pack(r, seed), 1'b1, back);
        xfer(pack(r, seed), 1'b0, back);
        chk("config readback", pack(r, seed), back);
    endtask

    task automatic run(input logic builtin, input logic firstBit);
        int   n;
        logic firstSeen;
        @(posedge sys_clk) clrStats <= 1'b1;
        @(posedge sys_clk) clrStats <= 1'b0;
        start             <= 1'b1;
        builtinDefaultRun <= builtin;
        n = 0;
        while (scanCtrl.done !== 1'b1 && n < 20000) begin
            @(posedge sys_clk);
            n++;
            if (n == 2) firstSeen = prpgScanBit;
        end
        chk("first generator bit", firstBit, firstSeen);
        chk("done seen", 1, scanCtrl.done);
        chk("busy at done", 0, scanCtrl.busy);
        @(posedge sys_clk) start <= 1'b0;
        builtinDefaultRun <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("done released", 0, scanCtrl.done);
    endtask

    task automatic check_counts(input lbwcs_row_t r);
        int nc, ns, nsc, nReal;
        nc = 0;
        ns = 0;
        nsc = 0;
        for (int i = r.b; i <= r.e; i++) begin
            if (i < r.c) nc++;
            else if (i < r.c + r.s) ns++;
            else nsc++;
        end
        nReal = r.e - r.b + 1;
        chk("warm patterns", r.w, patCnt[LBWCS_PH_WARM]);
        chk("warm capture clocks", 0, trigCnt[LBWCS_PH_WARM]);
        chk("chain patterns", nc, patCnt[LBWCS_PH_CHAIN]);
        chk("chain capture cycles", nc, captCnt[LBWCS_PH_CHAIN]);
        chk("chain capture clocks", 0, trigCnt[LBWCS_PH_CHAIN]);
        chk("set reset patterns", ns, patCnt[LBWCS_PH_SR]);
        chk("set reset cycles", 2 * ns, asrCnt);
        chk("scan patterns", nsc, patCnt[LBWCS_PH_SCAN]);
        chk("scan capture clocks", 4 * nsc, trigCnt[LBWCS_PH_SCAN]);
        chk("signature cycles", nReal * L, accumCnt);
        chk("generator advances", (r.w + nReal) * L, advCnt);
        chk("signature clears", r.b == 0, clearCnt);
        chk("phase order", 0, orderBad);
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        logic [80:0] back;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            // Seed stands for the generator state the programming side preloads
            program_cfg(rows[k], 31'h1 + 31'(k));
            run(1'b0, 1'(k + 1));
            check_counts(rows[k]);
            if (rows[k].b == 0 && rows[k].w > 0) begin
                xfer('0, 1'b0, back);
                chk("warm copy", 0, back[80:73]);
            end
            $display("row %0d finished", k);
        end

        // Registers must ignore an update that lands while a run is busy
        program_cfg('{2, 0, 20, 0, 0}, 31'h7);
        fork
            run(1'b0, 1'b1);
            begin
                repeat (5) @(posedge sys_clk);
                xfer(pack('{9, 3, 30, 2, 1}, 31'h5), 1'b1, back);
            end
        join
        xfer('0, 1'b0, back);
        chk("update while busy", pack('{0, 0, 20, 0, 0}, 31'h7), back);
        $display("busy update test finished");

        program_cfg('{5, 3, 9, 1, 1}, 31'h3);
        run(1'b1, 1'(`LBWCS_PRPG_SEED));
        check_counts('{128, 0, 1023, 7, 0});
        $display("builtin default run finished");

        program_cfg('{0, 0, 5, 0, 0}, 31'h2);
        @(posedge sys_clk) start <= 1'b1;
        repeat (10) @(posedge sys_clk);
        srst  <= 1'b1;
        start <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("control in reset", 0, scanCtrl);
        chk("index in reset", 0, patternIndex);
        chk("phase in reset", LBWCS_PH_WARM, activePhase);
        srst <= 1'b0;
        xfer('0, 1'b0, back);
        chk("reset defaults", pack('{128, 0, 1023, 7, 0}, 31'h1), back);
        $display("mid run reset finished");
        end_of_test();
    end
endmodule
